// [src/froe_consts.vh]
// Constants for the file register operation execute block
`ifndef FROE_CONSTS_VH
`define FROE_CONSTS_VH

// Operation codes on the instruction field port
`define FROE_OP_NOP 3'h0
`define FROE_OP_CLRWD 3'h1
`define FROE_OP_CLRFILE 3'h2
`define FROE_OP_COMPL 3'h3
`define FROE_OP_DEC 3'h4
`define FROE_OP_DECSKIP 3'h5
`define FROE_OP_INC 3'h6
`define FROE_OP_INCSKIP 3'h7

// Register byte addresses
`define FROE_ADDR_CTRL 8'h00
`define FROE_ADDR_STATUS 8'h04
`define FROE_ADDR_WREG 8'h08
`define FROE_ADDR_WDOG 8'h0C
`define FROE_ADDR_FILE_BASE 8'h80

// Field positions
`define FROE_CTRL_PRESC_WDOG_BIT 0
`define FROE_STAT_ZERO_BIT 0
`define FROE_STAT_PD_N_BIT 1
`define FROE_STAT_TO_N_BIT 2
`define FROE_WDOG_CNT_LSB 0
`define FROE_WDOG_PRESC_LSB 8

// Reset values
`define FROE_CTRL_RST 1'h1
`define FROE_WREG_RST 8'h00
`define FROE_FILE_RST 8'h00
`define FROE_ZERO_RST 1'h0
`define FROE_FLAG_N_RST 1'h1
`define FROE_WDOG_RST 8'h00
`define FROE_PRESC_RST 8'h00

// Values loaded by the operations
`define FROE_CLEAR_VAL 8'h00
`define FROE_FLAG_SET 1'h1

`endif

// [src/froe_alu.v]
// Result, flag and skip computation for the single-operand file operations
`timescale 1ns/100ps
`default_nettype none
`include "froe_consts.vh"

module froe_alu #(
   parameter DW = 8
) (
   input wire [2:0] op,
   input wire [DW-1:0] fval,
   output reg [DW-1:0] result,
   output reg wr_en,
   output reg force_file,
   output reg upd_zero,
   output wire zero_val,
   output reg skip,
   output reg wdog_clr
);

   always @* begin
      result = fval;
      wr_en = 1'b0;
      force_file = 1'b0;
      upd_zero = 1'b0;
      wdog_clr = 1'b0;
      case (op)
         `FROE_OP_CLRWD: begin
            wdog_clr = 1'b1;
         end
         `FROE_OP_CLRFILE: begin
            result = `FROE_CLEAR_VAL;
            wr_en = 1'b1;
            force_file = 1'b1;
            upd_zero = 1'b1;
         end
         `FROE_OP_COMPL: begin
            result = ~fval;
            wr_en = 1'b1;
            upd_zero = 1'b1;
         end
         `FROE_OP_DEC: begin
            result = fval - {{(DW-1){1'b0}}, 1'b1};
            wr_en = 1'b1;
            upd_zero = 1'b1;
         end
         `FROE_OP_DECSKIP: begin
            result = fval - {{(DW-1){1'b0}}, 1'b1};
            wr_en = 1'b1;
         end
         `FROE_OP_INC: begin
            result = fval + {{(DW-1){1'b0}}, 1'b1};
            wr_en = 1'b1;
            upd_zero = 1'b1;
         end
         `FROE_OP_INCSKIP: begin
            result = fval + {{(DW-1){1'b0}}, 1'b1};
            wr_en = 1'b1;
         end
         default: begin
            result = fval;
         end
      endcase
   end

   // Zero test on the full result width; clear always yields zero
   assign zero_val = (result == {DW{1'b0}});

   always @* begin
      skip = 1'b0;
      if ((op == `FROE_OP_DECSKIP) || (op == `FROE_OP_INCSKIP)) begin
         skip = zero_val;
      end
   end

endmodule
`default_nettype wire

// [src/froe_regfile.v]
// File register array with one write port and two read ports
`timescale 1ns/100ps
`default_nettype none
`include "froe_consts.vh"

module froe_regfile #(
   parameter DW = 8,
   parameter AW = 5
) (
   input wire clk,
   input wire rst_n,
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [DW-1:0] wdata,
   input wire [AW-1:0] raddr_a,
   output wire [DW-1:0] rdata_a,
   input wire [AW-1:0] raddr_b,
   output wire [DW-1:0] rdata_b
);

   localparam DEPTH = 1 << AW;

   reg [DW-1:0] mem [0:DEPTH-1];
   integer i;

   always @(posedge clk) begin
      if (!rst_n) begin
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem[i] <= `FROE_FILE_RST;
         end
      end else if (we) begin
         mem[waddr] <= wdata;
      end
   end

   assign rdata_a = mem[raddr_a];
   assign rdata_b = mem[raddr_b];

endmodule
`default_nettype wire

// [src/froe_top.v]
// Execute stage for single-operand file operations with an APB register slave
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "froe_consts.vh"

// Operation
// - Clear watchdog loads watchdog counter zero
// - Clear watchdog zeroes prescaler when assigned watchdog
// - Clear watchdog sets timeout and powerdown flags
// - Clear file writes zero, sets zero flag
// - Complement inverts file, routes, updates zero
// - Destination bit selects working or file register
// - Decrement subtracts one, updates zero flag
// - Decrement-skip leaves flags, skips on zero
// - Taken skip replaces prefetched instruction with no-op
// - Increment adds one, updates zero flag
// - Increment-skip leaves flags, skips on wrap
// - Five-bit file address, one destination bit
module froe_top #(
   parameter DW = 8,
   parameter AW = 5
) (
   input wire MCLK,
   input wire RSTN,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [7:0] PADDR,
   input wire [31:0] PWDATA,
   output reg PREADY,
   output reg [31:0] PRDATA,
   output reg PSLVERR,
   input wire OP_VALID,
   input wire [2:0] OP_CODE,
   input wire [AW-1:0] OP_FADDR,
   input wire OP_DEST,
   input wire WDOG_TICK,
   input wire PRESC_TICK,
   input wire TIMEOUT_EVT,
   input wire SLEEP_EVT,
   output reg [DW-1:0] W_REG,
   output reg ZERO_FLAG,
   output reg TIMEOUT_N,
   output reg POWERDOWN_N,
   output reg [7:0] WDOG_COUNT,
   output reg [7:0] PRESCALE_COUNT,
   output reg PRESC_TO_WDOG,
   output reg SKIP_PENDING,
   output reg OP_DONE,
   output reg OP_SKIPPED
);

   // Counter step
   localparam [7:0] ONE8 = 8'h01;

   // APB handshake and decode
   wire setup_ph;
   wire access_ph;
   wire apb_wr;
   reg [31:0] rd_mux;
   reg map_hit;
   // Software write strobes and registered APB response
   wire wr_ctrl;
   wire wr_wreg;
   wire wr_file;
   reg pready_nxt;
   reg [31:0] prdata_nxt;
   reg pslverr_nxt;

   // Execution path
   wire exec;
   wire discard;
   wire [DW-1:0] file_rd;
   wire [DW-1:0] apb_file_rd;
   wire [DW-1:0] alu_res;
   wire alu_wr;
   wire alu_force_file;
   wire alu_upd_z;
   wire alu_zero;
   wire alu_skip;
   wire alu_wdog_clr;
   wire to_file;
   wire to_wreg;
   wire file_we;
   wire [AW-1:0] file_waddr;
   wire [DW-1:0] file_wdata;

   reg skip_pend_r;
   reg skip_pend_nxt;
   reg [DW-1:0] w_nxt;
   reg zero_nxt;
   reg to_n_nxt;
   reg pd_n_nxt;
   reg [7:0] wdog_nxt;
   reg [7:0] presc_nxt;
   reg ctrl_nxt;

   // Byte address of a file register slot
   function is_file_addr;
      input [7:0] addr;
      begin
         is_file_addr = (addr[7] == 1'b1) && (addr[1:0] == 2'b00);
      end
   endfunction

   // Word index of a file register slot
   function [AW-1:0] file_index;
      input [7:0] addr;
      begin
         file_index = addr[AW+1:2];
      end
   endfunction

   // Register select for a fixed word offset
   function is_reg;
      input [7:0] addr;
      input [7:0] off;
      begin
         is_reg = (addr == off);
      end
   endfunction

   assign setup_ph = PSEL & ~PENABLE;
   assign access_ph = PSEL & PENABLE & PREADY;
   assign apb_wr = access_ph & PWRITE & ~PSLVERR;

   // Software write strobes, one per target
   assign wr_ctrl = apb_wr & is_reg(PADDR, `FROE_ADDR_CTRL);
   assign wr_wreg = apb_wr & is_reg(PADDR, `FROE_ADDR_WREG);
   assign wr_file = apb_wr & is_file_addr(PADDR);

   // Prefetched instruction after a taken skip is dropped
   assign exec = OP_VALID & ~skip_pend_r;
   assign discard = OP_VALID & skip_pend_r;

   froe_alu #(
      .DW(DW)
   ) u_alu (
      .op(OP_CODE),
      .fval(file_rd),
      .result(alu_res),
      .wr_en(alu_wr),
      .force_file(alu_force_file),
      .upd_zero(alu_upd_z),
      .zero_val(alu_zero),
      .skip(alu_skip),
      .wdog_clr(alu_wdog_clr)
   );

   // Destination select; clear file has no select bit
   assign to_file = exec & alu_wr & (alu_force_file | OP_DEST);
   assign to_wreg = exec & alu_wr & ~alu_force_file & ~OP_DEST;

   // Execution write beats a software write in the same cycle
   assign file_we = to_file | wr_file;
   assign file_waddr = to_file ? OP_FADDR : file_index(PADDR);
   assign file_wdata = to_file ? alu_res : PWDATA[DW-1:0];

   froe_regfile #(
      .DW(DW),
      .AW(AW)
   ) u_file (
      .clk(MCLK),
      .rst_n(RSTN),
      .we(file_we),
      .waddr(file_waddr),
      .wdata(file_wdata),
      .raddr_a(OP_FADDR),
      .rdata_a(file_rd),
      .raddr_b(file_index(PADDR)),
      .rdata_b(apb_file_rd)
   );

   // Read data and map decode
   always @* begin
      rd_mux = 32'h00000000;
      map_hit = 1'b1;
      if (is_file_addr(PADDR)) begin
         rd_mux[DW-1:0] = apb_file_rd;
      end else begin
         case (PADDR)
            `FROE_ADDR_CTRL: begin
               rd_mux[`FROE_CTRL_PRESC_WDOG_BIT] = PRESC_TO_WDOG;
            end
            `FROE_ADDR_STATUS: begin
               rd_mux[`FROE_STAT_ZERO_BIT] = ZERO_FLAG;
               rd_mux[`FROE_STAT_PD_N_BIT] = POWERDOWN_N;
               rd_mux[`FROE_STAT_TO_N_BIT] = TIMEOUT_N;
            end
            `FROE_ADDR_WREG: begin
               rd_mux[DW-1:0] = W_REG;
            end
            `FROE_ADDR_WDOG: begin
               rd_mux[`FROE_WDOG_CNT_LSB+7:`FROE_WDOG_CNT_LSB] = WDOG_COUNT;
               rd_mux[`FROE_WDOG_PRESC_LSB+7:`FROE_WDOG_PRESC_LSB] = PRESCALE_COUNT;
            end
            default: begin
               map_hit = 1'b0;
            end
         endcase
      end
   end

   // Skip bookkeeping: set by a taken skip, consumed by the next fetched word
   always @* begin
      skip_pend_nxt = skip_pend_r;
      if (discard) begin
         skip_pend_nxt = 1'b0;
      end else if (exec & alu_skip) begin
         skip_pend_nxt = 1'b1;
      end
   end

   // Working register
   always @* begin
      w_nxt = W_REG;
      if (to_wreg) begin
         w_nxt = alu_res;
      end else if (wr_wreg) begin
         w_nxt = PWDATA[DW-1:0];
      end
   end

   // Zero flag follows the result of flag-affecting operations only
   // Software has no write path to it
   always @* begin
      zero_nxt = ZERO_FLAG;
      if (exec & alu_upd_z) begin
         zero_nxt = alu_zero;
      end
   end

   // Active-low flags: the clear-watchdog set wins over a clearing event
   always @* begin
      to_n_nxt = TIMEOUT_N;
      pd_n_nxt = POWERDOWN_N;
      if (exec & alu_wdog_clr) begin
         to_n_nxt = `FROE_FLAG_SET;
         pd_n_nxt = `FROE_FLAG_SET;
      end else begin
         if (TIMEOUT_EVT) begin
            to_n_nxt = 1'b0;
         end
         if (SLEEP_EVT) begin
            pd_n_nxt = 1'b0;
         end
      end
   end

   // Watchdog counter and shared prescaler
   always @* begin
      wdog_nxt = WDOG_COUNT;
      presc_nxt = PRESCALE_COUNT;
      if (WDOG_TICK) begin
         wdog_nxt = WDOG_COUNT + ONE8;
      end
      if (PRESC_TICK) begin
         presc_nxt = PRESCALE_COUNT + ONE8;
      end
      if (exec & alu_wdog_clr) begin
         wdog_nxt = `FROE_CLEAR_VAL;
         if (PRESC_TO_WDOG) begin
            presc_nxt = `FROE_CLEAR_VAL;
         end
      end
   end

   // Prescaler assignment bit, written by software only
   always @* begin
      ctrl_nxt = PRESC_TO_WDOG;
      if (wr_ctrl) begin
         ctrl_nxt = PWDATA[`FROE_CTRL_PRESC_WDOG_BIT];
      end
   end

   // Core state
   always @(posedge MCLK) begin
      if (!RSTN) begin
         skip_pend_r <= 1'b0;
         SKIP_PENDING <= 1'b0;
         W_REG <= `FROE_WREG_RST;
         ZERO_FLAG <= `FROE_ZERO_RST;
         OP_DONE <= 1'b0;
         OP_SKIPPED <= 1'b0;
      end else begin
         skip_pend_r <= skip_pend_nxt;
         SKIP_PENDING <= skip_pend_nxt;
         W_REG <= w_nxt;
         ZERO_FLAG <= zero_nxt;
         OP_DONE <= exec;
         OP_SKIPPED <= discard;
      end
   end

   // Watchdog side state
   always @(posedge MCLK) begin
      if (!RSTN) begin
         TIMEOUT_N <= `FROE_FLAG_N_RST;
         POWERDOWN_N <= `FROE_FLAG_N_RST;
         WDOG_COUNT <= `FROE_WDOG_RST;
         PRESCALE_COUNT <= `FROE_PRESC_RST;
         PRESC_TO_WDOG <= `FROE_CTRL_RST;
      end else begin
         TIMEOUT_N <= to_n_nxt;
         POWERDOWN_N <= pd_n_nxt;
         WDOG_COUNT <= wdog_nxt;
         PRESCALE_COUNT <= presc_nxt;
         PRESC_TO_WDOG <= ctrl_nxt;
      end
   end

   // APB slave: one wait-free access phase after each setup cycle
   always @* begin
      pready_nxt = setup_ph;
      prdata_nxt = PRDATA;
      pslverr_nxt = PSLVERR;
      if (setup_ph) begin
         pslverr_nxt = ~map_hit;
         if (!PWRITE && map_hit) begin
            prdata_nxt = rd_mux;
         end else begin
            prdata_nxt = 32'h00000000;
         end
      end else if (access_ph) begin
         pslverr_nxt = 1'b0;
      end
   end

   // Response registers
   always @(posedge MCLK) begin
      if (!RSTN) begin
         PREADY <= 1'b0;
         PRDATA <= 32'h00000000;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= pready_nxt;
         PRDATA <= prdata_nxt;
         PSLVERR <= pslverr_nxt;
      end
   end

endmodule
`default_nettype wire

// [test/froe_top_sva.sv]
// Checker for the instruction side of the execute block
`timescale 1ns/100ps
`default_nettype none
module froe_top_sva #(
   parameter DW = 8,
   parameter AW = 5
) (
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic OP_VALID,
   input wire logic [2:0] OP_CODE,
   input wire logic OP_DEST,
   input wire logic [DW-1:0] W_REG,
   input wire logic ZERO_FLAG,
   input wire logic TIMEOUT_N,
   input wire logic POWERDOWN_N,
   input wire logic [7:0] WDOG_COUNT,
   input wire logic [7:0] PRESCALE_COUNT,
   input wire logic PRESC_TO_WDOG,
   input wire logic SKIP_PENDING,
   input wire logic OP_DONE,
   input wire logic OP_SKIPPED
);
   default clocking @(posedge MCLK);
   endclocking
   default disable iff (!RSTN);
   wire logic ex = OP_VALID && !SKIP_PENDING;
   wire logic cw = ex && OP_CODE == 3'h1;
   a_wd_count: assert property (cw |=> WDOG_COUNT == 8'h00)
      else $error("watchdog not cleared");
   a_wd_presc: assert property (cw && PRESC_TO_WDOG |=> PRESCALE_COUNT == 8'h00)
      else $error("prescaler not cleared");
   a_wd_flags: assert property (cw |=> TIMEOUT_N && POWERDOWN_N && $stable(ZERO_FLAG))
      else $error("watchdog clear flags wrong");
   a_clr_zero: assert property (ex && OP_CODE == 3'h2 |=> ZERO_FLAG)
      else $error("clear file zero flag low");
   a_zero_res: assert property (ex && !OP_DEST && OP_CODE inside {3'h3, 3'h4, 3'h6}
      |=> ZERO_FLAG == (W_REG == '0))
      else $error("zero flag disagrees with result");
   a_skip_flag: assert property (ex && OP_CODE[2] && OP_CODE[0] |=> $stable(ZERO_FLAG))
      else $error("skip op changed zero flag");
   a_skip_set: assert property (ex && OP_CODE[2] && OP_CODE[0] && !OP_DEST
      |=> SKIP_PENDING == (W_REG == '0))
      else $error("skip decision wrong");
   a_skip_none: assert property (ex && !(OP_CODE[2] && OP_CODE[0]) |=> !SKIP_PENDING)
      else $error("skip without cause");
   a_discard: assert property (OP_VALID && SKIP_PENDING
      |=> OP_SKIPPED && !OP_DONE && !SKIP_PENDING && $stable(W_REG))
      else $error("discard wrong");
   a_done_one: assert property (ex |=> OP_DONE && !OP_SKIPPED)
      else $error("done missing");
   a_w_hold: assert property (ex && (OP_DEST || OP_CODE <= 3'h2) |=> $stable(W_REG))
      else $error("working reg changed");
endmodule
bind froe_top froe_top_sva #(.DW(DW), .AW(AW)) u_sva (.MCLK, .RSTN, .OP_VALID, .OP_CODE,
   .OP_DEST, .W_REG, .ZERO_FLAG, .TIMEOUT_N, .POWERDOWN_N, .WDOG_COUNT, .PRESCALE_COUNT,
   .PRESC_TO_WDOG, .SKIP_PENDING, .OP_DONE, .OP_SKIPPED);
`default_nettype wire

// [test/froe_pmem.sv]
// Program memory model presenting one fetched word per request
`timescale 1ns/100ps
`default_nettype none
module froe_pmem (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic fetch,
   input wire logic [8:0] word,
   output logic op_valid,
   output logic [8:0] fields
);
   always @(posedge clk) begin
      if (!rst_n) begin
         op_valid <= 1'b0;
         fields <= 9'h000;
      end else begin
         op_valid <= fetch;
         // Idle fields toggle so stale words are never mistaken for fresh ones
         fields <= fetch ? word : ~fields;
      end
   end
endmodule
`default_nettype wire

// [test/froe_top_tb.sv]
// Self-checking bench for the file register execute block
`timescale 1ns/100ps
`default_nettype none
`include "froe_consts.vh"
module froe_top_tb;
   logic MCLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, OP_VALID, OP_DEST, fetch, z_m, sk;
   logic WDOG_TICK, PRESC_TICK, TIMEOUT_EVT, SLEEP_EVT, ZERO_FLAG, TIMEOUT_N, POWERDOWN_N;
   logic PRESC_TO_WDOG, SKIP_PENDING, OP_DONE, OP_SKIPPED, d, p;
   logic [31:0] PWDATA, PRDATA;
   logic [2:0] OP_CODE, code;
   logic [4:0] OP_FADDR, fa;
   logic [8:0] word;
   logic [7:0] PADDR, W_REG, WDOG_COUNT, PRESCALE_COUNT, w_m, res, init, fx, ad;
   int err_total = 0, total_checks = 0, cyc = 0;
   logic [16:0] tbl [11] = '{{3'h3, 5'h00, 1'h0, 8'h5A}, {3'h5, 5'h06, 1'h1, 8'h01},
      {3'h3, 5'h1F, 1'h1, 8'hFF}, {3'h7, 5'h08, 1'h0, 8'h10}, {3'h4, 5'h01, 1'h1, 8'h01},
      {3'h4, 5'h02, 1'h0, 8'h00}, {3'h7, 5'h07, 1'h0, 8'hFF}, {3'h2, 5'h05, 1'h0, 8'h33},
      {3'h6, 5'h03, 1'h1, 8'hFF}, {3'h6, 5'h04, 1'h0, 8'h7F}, {3'h5, 5'h09, 1'h0, 8'h05}};
   froe_top dut (.MCLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY, .PRDATA,
      .PSLVERR, .OP_VALID, .OP_CODE, .OP_FADDR, .OP_DEST, .WDOG_TICK, .PRESC_TICK,
      .TIMEOUT_EVT, .SLEEP_EVT, .W_REG, .ZERO_FLAG, .TIMEOUT_N, .POWERDOWN_N, .WDOG_COUNT,
      .PRESCALE_COUNT, .PRESC_TO_WDOG, .SKIP_PENDING, .OP_DONE, .OP_SKIPPED);
   froe_pmem u_pmem (.clk(MCLK), .rst_n(RSTN), .fetch, .word, .op_valid(OP_VALID),
      .fields({OP_CODE, OP_FADDR, OP_DEST}));
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         err_total++;
         $display("unexpected at %0t: saw %h want %h", $time, s, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
      input logic [31:0] e, input logic er);
      @(posedge MCLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= wd;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge MCLK);
      end while (PREADY !== 1'b1);
      chk(PRDATA, e);
      chk(PSLVERR, er);
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic exec(input logic [8:0] iw, input logic done);
      @(posedge MCLK);
      fetch <= 1'b1;
      word <= iw;
      @(posedge MCLK);
      fetch <= 1'b0;
      @(posedge MCLK);
      #1;
      chk({OP_DONE, OP_SKIPPED}, {done, !done});
   endtask
   initial begin
      MCLK = 1'b0;
      forever #12.5 MCLK = ~MCLK;
   end
   initial begin
      forever begin
         @(posedge MCLK);
         cyc++;
         if (cyc > 3000) begin
            err_total++;
            end_sim();
         end
      end
   end
   initial begin
      {RSTN, PSEL, PENABLE, PWRITE, fetch, WDOG_TICK, PRESC_TICK, TIMEOUT_EVT, SLEEP_EVT} = '0;
      PADDR = 8'h00;
      PWDATA = 32'h0;
      word = 9'h000;
      repeat (12) @(posedge MCLK);
      RSTN <= 1'b1;
      apb(0, `FROE_ADDR_STATUS, 0, 32'h6, 0);
      apb(1, 8'h10, 32'hFF, 0, 1);
      apb(0, 8'h10, 0, 0, 1);
      w_m = 8'h00;
      z_m = 1'b0;
      foreach (tbl[i]) begin
         {code, fa, d, init} = tbl[i];
         ad = `FROE_ADDR_FILE_BASE + {fa, 2'b00};
         apb(1, ad, {24'h0, init}, 0, 0);
         case (code)
            3'h2: res = 8'h00;
            3'h3: res = ~init;
            3'h4, 3'h5: res = init - 8'h01;
            default: res = init + 8'h01;
         endcase
         if (!code[0] || code == 3'h3) z_m = res == 8'h00;
         sk = code[2] && code[0] && res == 8'h00;
         fx = (d || code == 3'h2) ? res : init;
         if (!d && code != 3'h2) w_m = res;
         exec({code, fa, d}, 1'b1);
         chk(W_REG, w_m);
         chk(ZERO_FLAG, z_m);
         chk(SKIP_PENDING, sk);
         apb(0, ad, 0, fx, 0);
         if (sk) begin
            exec({3'h6, fa, 1'b1}, 1'b0);
            apb(0, ad, 0, fx, 0);
            chk(SKIP_PENDING, 1'b0);
         end
      end
      apb(0, `FROE_ADDR_WREG, 0, {24'h0, w_m}, 0);
      exec(9'h001, 1'b1);
      chk({W_REG, ZERO_FLAG}, {w_m, z_m});
      for (int k = 0; k < 2; k++) begin
         p = k == 0;
         apb(1, `FROE_ADDR_CTRL, {31'h0, p}, 0, 0);
         @(posedge MCLK);
         {WDOG_TICK, PRESC_TICK, TIMEOUT_EVT, SLEEP_EVT} <= 4'hF;
         @(posedge MCLK);
         {WDOG_TICK, PRESC_TICK, TIMEOUT_EVT, SLEEP_EVT} <= 4'h0;
         @(posedge MCLK);
         #1;
         chk({WDOG_COUNT, PRESCALE_COUNT, TIMEOUT_N, POWERDOWN_N}, 18'h00404);
         exec({`FROE_OP_CLRWD, 6'h00}, 1'b1);
         chk({PRESC_TO_WDOG, TIMEOUT_N, POWERDOWN_N, ZERO_FLAG}, {p, 2'b11, z_m});
         chk(WDOG_COUNT, 8'h00);
         chk(PRESCALE_COUNT, {7'h0, !p});
         apb(0, `FROE_ADDR_WDOG, 0, {16'h0, 7'h0, !p, 8'h00}, 0);
      end
      end_sim();
   end
endmodule
`default_nettype wire
